/* rtl/clk_gate_cell.sv */
`timescale 1ns/100ps
// enable register for a gated clock; enable only changes on a clean boundary
module clk_gate_cell (
   input wire logic clk,          // system clock
   input wire logic rst_b,        // async reset, active low
   input wire logic boundary,     // one-cycle strobe at the gated clock boundary
   input wire logic en_req,       // requested enable
   output logic en                // registered enable
);
   logic nxt_en;

   // hold the enable until the affected clock reaches its boundary
   always_comb begin
      nxt_en = boundary ? en_req : en;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en <= 1'b1;
      end else begin
         en <= nxt_en;
      end
   end
endmodule : clk_gate_cell

/* rtl/pin_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous pins
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,              // system clock
   input wire logic rst_b,            // async reset, active low
   input wire logic [WIDTH-1:0] d,    // asynchronous inputs
   output logic [WIDTH-1:0] q         // synchronised outputs
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_q;

   // first stage is read only by the second
   always_comb begin
      nxt_meta = d;
      nxt_q = meta_ff;
   end

   // no reset on purpose: straps must be settled here by the time reset is released
   always_ff @(posedge clk) begin
      meta_ff <= nxt_meta;
      q <= nxt_q;
   end
endmodule : pin_sync

/* rtl/pmc_pkg.sv */
package pmc_pkg;
   // operating modes held by the controller
   typedef enum logic [1:0] {
      MODE_FULL,
      MODE_ACTIVE,
      MODE_SLEEP,
      MODE_DEEP
   } pmode_t;

   // software view of the pll control register fields
   typedef struct packed {
      logic [1:0] sys_div_sel;   // core to system clock ratio select
      logic bypass;              // pll bypass request
      logic pll_off;             // request pll disable (deep sleep)
      logic sleep;               // request core clock stop
   } pll_control_register_t;

   // clock and pll controls driven out of the block
   typedef struct packed {
      logic pll_en;
      logic pll_bypass;
      logic core_clk_en;
      logic sys_clk_en;
   } clk_ctl_t;

   localparam logic [1:0] SYS_DIV_2P0 = 2'h0;
   localparam logic [1:0] SYS_DIV_2P5 = 2'h1;
   localparam logic [1:0] SYS_DIV_3P0 = 2'h2;
   localparam logic [1:0] SYS_DIV_4P0 = 2'h3;
   // system divider period in half-core-clock units (2.5:1 needs halves)
   localparam logic [3:0] HALF_CNT_2P0 = 4'h4;
   localparam logic [3:0] HALF_CNT_2P5 = 4'h5;
   localparam logic [3:0] HALF_CNT_3P0 = 4'h6;
   localparam logic [3:0] HALF_CNT_4P0 = 4'h8;
   // core clock divides input clock by two when bypassed
   localparam logic [3:0] BYPASS_CORE_DIV = 4'h2;
   localparam logic [1:0] RESET_DIV_SEL = 2'h0;
   localparam pmode_t RESET_MODE = MODE_FULL;
endpackage : pmc_pkg

/* rtl/power_mode_controller.sv */
`timescale 1ns/100ps
// Notes on behaviour
// [R1] full speed: pll on, not bypassed, core and system clocks running
// [R2] reduced speed: pll on and bypassed, core clock at half input clock
// [R3] in reduced speed, divider select written by software is applied
// [R4] system dma to l1 allowed in reduced speed mode
// [R5] sleep: core clock stopped, pll and system clock keep running
// [R6] sleep wakes on any interrupt; bypass bit picks full or reduced speed
// [R7] system dma to l1 refused while sleeping
// [R8] deep sleep: pll off, core and system clocks stopped
// [R9] deep sleep: async peripherals run but are blocked from resources
// [R10] deep sleep exits only on reset or rtc async interrupt
// [R11] reset in deep sleep: bypass pin picks full or reduced speed
// [R12] rtc wake from deep sleep always goes to full speed
// [R13] deep sleep indicator high exactly while in deep sleep
// [R14] software mode change only after control write plus programming sequence
// [R15] software should halt dma across mode transitions
// [R16] divider select: 00 2:1, 01 2.5:1, 10 3:1, 11 4:1
// [R17] divider reset value sampled from two strap pins during reset
// [R18] mode held in a register; gates switch only on clock boundaries
module power_mode_controller
   import pmc_pkg::*;
(
   input wire logic clk,                        // 100 MHz clock, input clock domain
   input wire logic rst_b,                      // async reset, active low
   input wire logic bypass_pin,                 // bypass strap pin (asynchronous)
   input wire logic [1:0] div_strap_pin,        // divider strap pins (asynchronous)
   input wire logic ctl_wr,                     // pll control register write strobe
   input wire pmc_pkg::pll_control_register_t ctl_wdata,     // pll control register write data
   input wire logic prog_seq_idle,              // core idle with irqs off, sequence run
   input wire logic irq_any,                    // any interrupt asserted, same domain
   input wire logic rtc_wake_irq,               // rtc asynchronous interrupt (async)
   input wire logic dma_l1_req,                 // system dma request toward l1
   output pmc_pkg::pmode_t mode,                // current operating mode
   output pmc_pkg::pll_control_register_t ctl_rdata,         // pll control register readback
   output pmc_pkg::clk_ctl_t clk_ctl,           // pll and clock gate controls
   output logic [3:0] core_div,                 // input to core clock divide
   output logic [3:0] sys_half_cnt,             // system period in half core cycles
   output logic dma_l1_grant,                   // dma to l1 accepted
   output logic async_periph_block,             // async peripherals fenced off
   output logic deep_sleep_indicator            // deep sleep pin, active high
);
   import pmc_pkg::*;

   pmode_t mode_ff, nxt_mode;
   pll_control_register_t ctl_ff, nxt_ctl;
   logic [3:0] half_cnt_ff, nxt_half_cnt;
   logic [3:0] phase_ff, nxt_phase;
   logic strap_pend_ff, nxt_strap_pend;
   logic bypass_s;
   logic [1:0] div_strap_s;
   logic rtc_s;
   logic sys_boundary;
   logic core_en, sys_en, pll_en, pll_byp;
   logic core_req, sys_req, pll_en_req, pll_byp_req;
   logic [3:0] sel_half_cnt;
   logic out_dma_ff, nxt_out_dma;

   // pins come from outside the clock domain
   pin_sync #(.WIDTH(4)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({bypass_pin, div_strap_pin, rtc_wake_irq}),
      .q({bypass_s, div_strap_s, rtc_s})
   );

   // divider select decode to half-cycle counts
   always_comb begin
      unique case (ctl_ff.sys_div_sel)
         SYS_DIV_2P0: sel_half_cnt = HALF_CNT_2P0; // [R16]
         SYS_DIV_2P5: sel_half_cnt = HALF_CNT_2P5; // [R16]
         SYS_DIV_3P0: sel_half_cnt = HALF_CNT_3P0; // [R16]
         SYS_DIV_4P0: sel_half_cnt = HALF_CNT_4P0; // [R16]
      endcase
   end

   // mode state machine and control register
   always_comb begin
      nxt_mode = mode_ff;
      nxt_ctl = ctl_ff;
      nxt_strap_pend = 1'b0;
      // synchroniser runs through reset, so the straps are settled at release
      if (strap_pend_ff) begin
         nxt_ctl.sys_div_sel = div_strap_s; // [R17]
         nxt_ctl.bypass = bypass_s; // [R11]
         nxt_mode = bypass_s ? MODE_ACTIVE : MODE_FULL; // [R11]
      end
      // writes only land in the register; mode waits for the sequence
      if (ctl_wr) begin
         nxt_ctl = ctl_wdata; // [R14]
         // divider change applies in any running mode, including reduced speed
         nxt_ctl.sleep = ctl_wdata.sleep; // [R3]
      end
      unique case (mode_ff)
         MODE_FULL, MODE_ACTIVE: begin
            if (prog_seq_idle && !strap_pend_ff) begin // [R14]
               if (ctl_ff.pll_off) begin
                  nxt_mode = MODE_DEEP; // [R8]
               end else if (ctl_ff.sleep) begin
                  nxt_mode = MODE_SLEEP; // [R5]
               end else begin
                  nxt_mode = ctl_ff.bypass ? MODE_ACTIVE : MODE_FULL;
               end
            end
         end
         MODE_SLEEP: begin
            // bypass bit is sampled at the wake
            if (irq_any) begin
               nxt_mode = ctl_ff.bypass ? MODE_ACTIVE : MODE_FULL; // [R6]
               nxt_ctl.sleep = 1'b0;
            end
         end
         MODE_DEEP: begin
            // ordinary interrupts are ignored here; reset is handled by rst_b
            if (rtc_s) begin // [R10]
               nxt_mode = MODE_FULL; // [R12]
               nxt_ctl.pll_off = 1'b0;
               nxt_ctl.sleep = 1'b0;
               nxt_ctl.bypass = 1'b0;
            end
         end
      endcase
   end

   // system clock divider phase: boundary at end of each system period
   always_comb begin
      nxt_half_cnt = half_cnt_ff;
      nxt_phase = phase_ff + 4'h2;
      sys_boundary = 1'b0;
      if (phase_ff + 4'h2 >= half_cnt_ff) begin
         sys_boundary = 1'b1;
         nxt_phase = 4'h0;
         nxt_half_cnt = sel_half_cnt; // [R3]
      end
   end

   // requested gate levels per mode
   always_comb begin
      core_req = (mode_ff == MODE_FULL) || (mode_ff == MODE_ACTIVE); // [R1] [R5]
      sys_req = (mode_ff != MODE_DEEP); // [R8]
      pll_en_req = (mode_ff != MODE_DEEP); // [R1] [R2] [R8]
      pll_byp_req = (mode_ff == MODE_ACTIVE) || // [R2]
                    (mode_ff == MODE_SLEEP && ctl_ff.bypass);
   end

   // gates only move on a system clock boundary, so no runt pulses
   clk_gate_cell u_core_gate (
      .clk(clk), .rst_b(rst_b), .boundary(sys_boundary), // [R18]
      .en_req(core_req), .en(core_en)
   );
   clk_gate_cell u_sys_gate (
      .clk(clk), .rst_b(rst_b), .boundary(sys_boundary), // [R18]
      .en_req(sys_req), .en(sys_en)
   );
   clk_gate_cell u_pll_en (
      .clk(clk), .rst_b(rst_b), .boundary(sys_boundary), // [R18]
      .en_req(pll_en_req), .en(pll_en)
   );
   clk_gate_cell u_pll_byp (
      .clk(clk), .rst_b(rst_b), .boundary(sys_boundary), // [R18]
      .en_req(pll_byp_req), .en(pll_byp)
   );

   // dma grant: accepted in full and reduced speed, refused asleep
   always_comb begin
      nxt_out_dma = dma_l1_req && // [R4] [R7]
                    (mode_ff == MODE_FULL || mode_ff == MODE_ACTIVE);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff <= RESET_MODE; // [R18]
         ctl_ff <= '{sys_div_sel: RESET_DIV_SEL, default: 1'b0};
         half_cnt_ff <= HALF_CNT_2P0;
         phase_ff <= 4'h0;
         strap_pend_ff <= 1'b1;
         out_dma_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         ctl_ff <= nxt_ctl;
         half_cnt_ff <= nxt_half_cnt;
         phase_ff <= nxt_phase;
         strap_pend_ff <= nxt_strap_pend;
         out_dma_ff <= nxt_out_dma;
      end
   end

   // outputs
   assign mode = mode_ff;
   assign ctl_rdata = ctl_ff;
   assign clk_ctl = '{pll_en: pll_en, pll_bypass: pll_byp,
                      core_clk_en: core_en, sys_clk_en: sys_en};
   // bypassed core runs at half input clock
   assign core_div = pll_byp ? BYPASS_CORE_DIV : 4'h1; // [R2]
   assign sys_half_cnt = half_cnt_ff;
   assign dma_l1_grant = out_dma_ff; // [R4] [R7]
   // async peripherals stay clocked but are fenced off in deep sleep
   assign async_periph_block = (mode_ff == MODE_DEEP); // [R9]
   assign deep_sleep_indicator = (mode_ff == MODE_DEEP); // [R13]
endmodule : power_mode_controller

/* verif/pmc_props.sv */
`timescale 1ns/100ps
// watches the controller ports only
module pmc_props
   import pmc_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_b, // async reset, active low
   input wire logic irq_any, // interrupt level
   input wire logic rtc_wake_irq, // rtc wake
   input wire logic dma_l1_req, // dma request
   input wire pmc_pkg::pmode_t mode, // mode
   input wire pmc_pkg::pll_control_register_t ctl_rdata, // control readback
   input wire pmc_pkg::clk_ctl_t clk_ctl, // clock controls
   input wire logic [3:0] core_div, // core divide
   input wire logic dma_l1_grant, // dma grant
   input wire logic async_periph_block, // fence
   input wire logic deep_sleep_indicator // deep sleep pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // gates move only at a boundary, so a mode is judged once it has held a while
   sequence s_held(pmode_t m);
      (mode == m) [*8];
   endsequence
   sequence s_rtc_in_deep;
      $rose(rtc_wake_irq) && mode == MODE_DEEP;
   endsequence
   a_full_clocks: assert property (s_held(MODE_FULL) |-> clk_ctl == 4'hb)
      else $error("full speed clocks wrong");
   a_active_clocks: assert property (s_held(MODE_ACTIVE) |-> clk_ctl == 4'hf && core_div == BYPASS_CORE_DIV)
      else $error("reduced speed clocks wrong");
   a_sleep_clocks: assert property (s_held(MODE_SLEEP) |-> clk_ctl.pll_en && !clk_ctl.core_clk_en && clk_ctl.sys_clk_en)
      else $error("sleep clocks wrong");
   a_deep_clocks: assert property (s_held(MODE_DEEP) |-> !clk_ctl.pll_en && !clk_ctl.core_clk_en && !clk_ctl.sys_clk_en)
      else $error("deep sleep clocks wrong");
   a_irq_wake: assert property (mode == MODE_SLEEP && irq_any |=> mode == ($past(ctl_rdata.bypass) ? MODE_ACTIVE : MODE_FULL))
      else $error("sleep wake target wrong");
   a_deep_ignore: assert property (mode == MODE_DEEP && !rtc_wake_irq && !$past(rtc_wake_irq) && !$past(rtc_wake_irq, 2) |=> mode == MODE_DEEP)
      else $error("deep sleep left without rtc");
   a_rtc_full: assert property (s_rtc_in_deep |-> ##[1:4] mode == MODE_FULL)
      else $error("rtc wake not to full speed");
   a_sleep_nodma: assert property ($past(mode) == MODE_SLEEP && mode == MODE_SLEEP |-> !dma_l1_grant)
      else $error("dma granted in sleep");
   a_active_dma: assert property (dma_l1_req && mode == MODE_ACTIVE ##1 mode == MODE_ACTIVE |-> dma_l1_grant)
      else $error("dma refused in reduced speed");
   a_deep_pin: assert property (deep_sleep_indicator == (mode == MODE_DEEP))
      else $error("deep sleep pin wrong");
   a_deep_fence: assert property (async_periph_block == (mode == MODE_DEEP))
      else $error("async fence wrong");
endmodule : pmc_props
bind power_mode_controller pmc_props i_pmc_props (.clk, .rst_b, .irq_any, .rtc_wake_irq,
   .dma_l1_req, .mode, .ctl_rdata, .clk_ctl, .core_div, .dma_l1_grant, .async_periph_block,
   .deep_sleep_indicator);

/* verif/power_mode_controller_test.sv */
`timescale 1ns/100ps
module power_mode_controller_test;
   import pmc_pkg::*;
   logic clk = 0, rst_b = 0, bypass_pin = 0, ctl_wr = 0, prog_seq_idle = 0;
   logic irq_go = 0, rtc_go = 0, dma_l1_req = 0, irq_any, rtc_wake_irq;
   logic dma_l1_grant, async_periph_block, deep_sleep_indicator;
   logic [1:0] div_strap_pin = 2'h0;
   logic [3:0] core_div, sys_half_cnt;
   pll_control_register_t ctl_wdata = '0, ctl_rdata;
   pmode_t mode;
   clk_ctl_t clk_ctl;
   int fail_count = 0, n_compared = 0;
   power_mode_controller i_power_mode_controller (.clk, .rst_b, .bypass_pin, .div_strap_pin,
      .ctl_wr, .ctl_wdata, .prog_seq_idle, .irq_any, .rtc_wake_irq, .dma_l1_req, .mode,
      .ctl_rdata, .clk_ctl, .core_div, .sys_half_cnt, .dma_l1_grant, .async_periph_block,
      .deep_sleep_indicator);
   wake_src_model i_wake_src_model (.clk, .rst_b, .irq_go, .rtc_go, .mode, .irq_any,
      .rtc_wake_irq);
   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic wrap_up;
      $display("compares %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic chk_mode(pmode_t exp);
      n_compared++;
      if (mode !== exp) begin
         fail_count++;
         $display("BAD %0t mode %0d want %0d", $time, mode, exp);
      end
   endtask : chk_mode
   task automatic chk_val(logic [3:0] got, logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t value %0h want %0h", $time, got, exp);
      end
   endtask : chk_val
   // straps must stay put through reset and the synchroniser
   task automatic do_reset(logic byp, logic [1:0] strap);
      @(negedge clk);
      bypass_pin = byp;
      div_strap_pin = strap;
      rst_b = 0;
      repeat (3) @(negedge clk);
      rst_b = 1;
      repeat (8) @(negedge clk);
   endtask : do_reset
   // control write, then the programming sequence one cycle later
   // dma request stays low across the whole transition
   task automatic prog_ctl(pll_control_register_t v);
      @(negedge clk);
      ctl_wr = 1;
      ctl_wdata = v;
      @(negedge clk);
      ctl_wr = 0;
      prog_seq_idle = 1;
      @(negedge clk);
      prog_seq_idle = 0;
      repeat (10) @(negedge clk);
   endtask : prog_ctl
   task automatic t_active;
      logic [3:0] tbl[4] = '{4'h4, 4'h5, 4'h6, 4'h8};
      for (int i = 0; i < 4; i++) begin
         prog_ctl({i[1:0], 3'h4});
         chk_mode(MODE_ACTIVE);
         chk_val(sys_half_cnt, tbl[i]);
      end
      chk_val(core_div, BYPASS_CORE_DIV);
      dma_l1_req = 1;
      repeat (2) @(negedge clk);
      chk_val({3'h0, dma_l1_grant}, 4'h1);
      dma_l1_req = 0;
   endtask : t_active
   task automatic t_sleep;
      for (int b = 1; b >= 0; b--) begin
         prog_ctl({2'h0, b[0], 2'h1});
         chk_mode(MODE_SLEEP);
         dma_l1_req = 1;
         repeat (2) @(negedge clk);
         chk_val({3'h0, dma_l1_grant}, 4'h0);
         dma_l1_req = 0;
         irq_go = 1;
         repeat (3) @(negedge clk);
         irq_go = 0;
         chk_mode(b ? MODE_ACTIVE : MODE_FULL);
      end
   endtask : t_sleep
   task automatic t_deep;
      prog_ctl({2'h0, 3'h2});
      chk_val({2'h0, deep_sleep_indicator, async_periph_block}, 4'h3);
      irq_go = 1;
      bypass_pin = 1;
      repeat (6) @(negedge clk);
      irq_go = 0;
      chk_mode(MODE_DEEP);
      rtc_go = 1;
      @(negedge clk);
      rtc_go = 0;
      repeat (6) @(negedge clk);
      chk_mode(MODE_FULL);
      chk_val({3'h0, deep_sleep_indicator}, 4'h0);
      prog_ctl({2'h0, 3'h2});
      do_reset(1, 2'h0);
      chk_mode(MODE_ACTIVE);
   endtask : t_deep
   // watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      #50000;
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      wrap_up();
   end
   initial begin
      do_reset(0, 2'h2);
      chk_mode(MODE_FULL);
      chk_val(sys_half_cnt, HALF_CNT_3P0);
      t_active();
      t_sleep();
      t_deep();
      wrap_up();
   end
endmodule : power_mode_controller_test

/* verif/wake_src_model.sv */
`timescale 1ns/100ps
// interrupt and rtc wake sources seen by the controller
module wake_src_model
   import pmc_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_b, // async reset, active low
   input wire logic irq_go, // bench asks for an interrupt
   input wire logic rtc_go, // bench fires an rtc event
   input wire pmc_pkg::pmode_t mode, // controller mode
   output logic irq_any, // interrupt level
   output logic rtc_wake_irq // rtc wake level
);
   logic irq_ff, rtc_ff, nxt_irq, nxt_rtc;
   // rtc line holds until serviced, since a dropped event would strand deep sleep
   always_comb begin
      nxt_irq = irq_go;
      nxt_rtc = (rtc_ff | rtc_go) & (mode != MODE_FULL);
   end
   // source registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ff <= 1'b0;
         rtc_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
         rtc_ff <= nxt_rtc;
      end
   end
   assign irq_any = irq_ff;
   assign rtc_wake_irq = rtc_ff;
endmodule : wake_src_model
